// ===== logic/lineif_tx_data_input.sv
// Purpose: Four-channel transmit data input stage: edge-selected rail
//          sampling, optional zero substitution, tip/ring drive.
// Assumes: All line-side pins are asynchronous to clk; each transmit clock
//          half period spans at least three clk cycles.
// Notes:   Registers over AHB-Lite; sampled symbols are logged in a FIFO, and overwriting an unlogged one sets a sticky lost flag.
`timescale 1ns/1ns
`include "lineif_consts.svh"
module lineif_tx_data_input
  import lineif_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              host_mode,
  input  wire logic              rail_single,
  input  wire logic              tx_clock_edge_select,
  input  wire logic [`N_CH-1:0]  tx_output_on,
  input  wire logic [`N_CH-1:0]  tx_channel_clock,
  input  wire logic [`N_CH-1:0]  tx_positive_rail,
  input  wire logic [`N_CH-1:0]  tx_negative_rail,
  output logic [`N_CH-1:0]       line_out_tip,
  output logic [`N_CH-1:0]       line_out_tip_oe,
  output logic [`N_CH-1:0]       line_out_ring,
  output logic [`N_CH-1:0]       line_out_ring_oe
);
  localparam int SW = 3 + 4 * `N_CH;

  logic [SW-1:0]    sync1;
  logic [SW-1:0]    sync2;
  logic [`N_CH-1:0] clk_s3;
  logic             hostm;
  logic             single_pin;
  logic             edge_pin;
  logic [`N_CH-1:0] on_s;
  logic [`N_CH-1:0] clk_s;
  logic [`N_CH-1:0] pos_s;
  logic [`N_CH-1:0] neg_s;
  logic [31:0]      ctrl;
  logic             edge_rise;
  logic             single;
  logic [`N_CH-1:0] eff_on;
  logic [`N_CH-1:0] samp;
  logic [`N_CH-1:0] enc_en;
  logic [7:0]       dly       [`N_CH];
  code_t [7:0]      sub       [`N_CH];
  logic [7:0]       next_dly  [`N_CH];
  code_t [7:0]      next_sub  [`N_CH];
  logic [1:0]       fire_pol  [`N_CH];
  logic [`N_CH-1:0] last_p;
  logic [`N_CH-1:0] par;
  logic [`N_CH-1:0] sym_p;
  logic [`N_CH-1:0] sym_n;
  logic [`N_CH-1:0] smp_pos;
  logic [`N_CH-1:0] smp_neg;
  logic [`N_CH-1:0] pend;
  logic [1:0]       pword     [`N_CH];
  logic [1:0]       gsel;
  logic             grant;
  logic             lost;
  logic             lost_clr;
  logic [`N_CH-1:0] lost_set;
  logic             accept;
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic [31:0]      rd_word;
  sym_fifo_if       fq ();

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and mode selection

  // Two flops on every pin; third stage only for clock edge finding
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1  <= '0;
      sync2  <= '0;
      clk_s3 <= '0;
    end else begin
      sync1  <= {host_mode, rail_single, tx_clock_edge_select, tx_output_on,
                 tx_channel_clock, tx_positive_rail, tx_negative_rail};
      sync2  <= sync1;
      clk_s3 <= clk_s;
    end
  end

  // Unpack the second stage only
  assign {hostm, single_pin, edge_pin, on_s, clk_s, pos_s, neg_s} = sync2;

  // Host mode ignores the shared select pin, which the far end grounds
  assign edge_rise = hostm ? ctrl[`CTRL_EDGE_BIT] : edge_pin;
  assign single    = hostm ? ctrl[`CTRL_SINGLE_BIT] : single_pin;
  assign eff_on    = hostm ? ctrl[`CTRL_ON_LSB +: `N_CH] : on_s;

  // Selected edge of each channel's own clock; rails ride the same sync depth
  assign samp = edge_rise ? (clk_s & ~clk_s3)
                          : (~clk_s & clk_s3);

  // Encoder on in single rail; hardware mode lets a low negative rail enable it
  assign enc_en = {`N_CH{single}} & ({`N_CH{hostm}} | ~neg_s);

  //////////////////////////////////////////////////////////////////////////////
  // Line coder

  // Symbol for the oldest delayed bit: {fire, positive}
  function automatic logic [1:0] emit(input code_t code, input logic bit_in,
                                      input logic lastp, input logic odd);
    logic fire;
    logic polp;
    fire = 1'b0;
    polp = ~lastp;
    unique case (sub_e'(code))
      SUB_NONE: fire = bit_in;
      SUB_V: begin
        fire = 1'b1;
        polp = lastp;               // Violation repeats last polarity
      end
      SUB_B:    fire = 1'b1;
      SUB_H:    fire = ~odd;        // Even pulse count since V: B00V
    endcase
    return {fire, polp};
  endfunction

  // Shift, mark zero runs, pick the outgoing symbol
  always_comb begin
    for (int c = 0; c < `N_CH; c++) begin
      next_dly[c] = {dly[c][6:0], pos_s[c]};
      next_sub[c] = {sub[c][6:0], SUB_NONE};
      if (enc_en[c] && ctrl[`CTRL_HDB3_BIT]) begin
        if (next_dly[c][3:0] == 4'h0 && next_sub[c][3:0] == '0) begin
          next_sub[c][3] = SUB_H;
          next_sub[c][0] = SUB_V;
        end
      end else if (enc_en[c]) begin
        if (next_dly[c] == 8'h00 && next_sub[c] == '0) begin
          next_sub[c][4] = SUB_V;
          next_sub[c][3] = SUB_B;
          next_sub[c][1] = SUB_V;
          next_sub[c][0] = SUB_B;
        end
      end
      fire_pol[c] = emit(sub[c][7], dly[c][7], last_p[c], par[c]);
      if (single) begin
        sym_p[c] = fire_pol[c][1] & fire_pol[c][0];
        sym_n[c] = fire_pol[c][1] & ~fire_pol[c][0];
      end else begin
        sym_p[c] = pos_s[c];
        sym_n[c] = neg_s[c] & ~pos_s[c];
      end
    end
  end

  // Coder state advances only on a channel's own sample
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < `N_CH; c++) begin
        dly[c] <= 8'h00;
        sub[c] <= '0;
      end
      last_p  <= '0;
      par     <= '0;
      smp_pos <= '0;
      smp_neg <= '0;
    end else begin
      for (int c = 0; c < `N_CH; c++) begin
        if (samp[c]) begin
          dly[c]     <= next_dly[c];
          sub[c]     <= next_sub[c];
          smp_pos[c] <= pos_s[c];
          smp_neg[c] <= neg_s[c];
          if (single && fire_pol[c][1]) begin
            last_p[c] <= fire_pol[c][0];
            par[c]    <= (sub[c][7] == SUB_V) ? 1'b0 : ~par[c];
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line drivers

  // Pulse holds for one line bit; off forces both low and released
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_out_tip     <= '0;
      line_out_ring    <= '0;
      line_out_tip_oe  <= '0;
      line_out_ring_oe <= '0;
    end else begin
      line_out_tip_oe  <= eff_on;
      line_out_ring_oe <= eff_on;
      for (int c = 0; c < `N_CH; c++) begin
        if (!eff_on[c]) begin
          line_out_tip[c]  <= 1'b0;
          line_out_ring[c] <= 1'b0;
        end else if (samp[c]) begin
          line_out_tip[c]  <= sym_p[c];
          line_out_ring[c] <= sym_n[c];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Symbol log

  // Lowest pending channel goes first; a full FIFO holds samples pending
  always_comb begin
    gsel = 2'h0;
    for (int c = `N_CH - 1; c >= 0; c--) begin
      if (pend[c]) begin
        gsel = 2'(c);
      end
    end
  end

  assign fq.in_valid = |pend;
  assign fq.in_data  = {gsel, pword[gsel]};
  assign grant       = fq.in_valid && fq.in_ready;

  // New sample wins over the grant that would clear it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend <= '0;
      for (int c = 0; c < `N_CH; c++) begin
        pword[c] <= 2'h0;
      end
    end else begin
      for (int c = 0; c < `N_CH; c++) begin
        if (samp[c]) begin
          pend[c]  <= 1'b1;
          pword[c] <= {sym_p[c], sym_n[c]};
        end else if (grant && gsel == 2'(c)) begin
          pend[c] <= 1'b0;
        end
      end
    end
  end

  // Overwriting an unlogged sample is sticky; set beats clear
  always_comb begin
    for (int c = 0; c < `N_CH; c++) begin
      lost_set[c] = samp[c] && pend[c] && !(grant && gsel == 2'(c));
    end
  end

  assign lost_clr = wr_pend && wr_addr == `ADDR_STATUS && hwdata[`ST_LOST_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lost <= 1'b0;
    end else if (|lost_set) begin
      lost <= 1'b1;
    end else if (lost_clr) begin
      lost <= 1'b0;
    end
  end

  sym_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_log (
    .clk   (clk),
    .rst_b (rst_b),
    .f     (fq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  assign accept       = hsel && htrans[1] && hready;
  assign fq.out_ready = accept && !hwrite && haddr[7:0] == `ADDR_DATA;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      `ADDR_CTRL:   rd_word = ctrl;
      `ADDR_STATUS: begin
        rd_word[`N_CH-1:0]        = smp_pos;
        rd_word[`N_CH +: `N_CH]   = smp_neg;
        rd_word[`ST_HOST_BIT]     = hostm;
        rd_word[`ST_LOST_BIT]     = lost;
        rd_word[`ST_AVAIL_BIT]    = fq.out_valid;
      end
      `ADDR_DATA: begin
        rd_word[`FIFO_WIDTH-1:0]  = fq.out_data;
        rd_word[`DATA_VALID_BIT]  = fq.out_valid;
      end
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // Read data taken at address phase so the pop and the word line up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= accept && hwrite;
      if (accept) begin
        wr_addr <= haddr[7:0];
      end
      if (accept && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Control written in the data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_pend && wr_addr == `ADDR_CTRL) begin
      ctrl <= hwdata & `CTRL_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks on channel 0

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_dual_on;
    samp[0] && !single && eff_on[0];
  endsequence
  sequence s_v_slot;
    samp[0] && single && eff_on[0] && sub[0][7] == SUB_V;
  endsequence

  a_rise_sample: assert property (samp[0] && edge_rise |-> clk_s[0] && !clk_s3[0])
    else $error("rising select sampled off a rising edge");
  a_fall_sample: assert property (samp[0] && !hostm && !edge_pin |-> !clk_s[0] && clk_s3[0])
    else $error("falling select sampled off a falling edge");
  a_no_overlap: assert property (!(line_out_tip[0] && line_out_ring[0]))
    else $error("tip and ring high together");
  a_off_release: assert property (!eff_on[0] |=> !line_out_tip_oe[0] && !line_out_ring_oe[0]
    && !line_out_tip[0] && !line_out_ring[0])
    else $error("channel driven while output off");
  a_rails_together: assert property (s_dual_on |=> smp_pos[0] == $past(pos_s[0])
    && smp_neg[0] == $past(neg_s[0]) && line_out_ring[0] == ($past(neg_s[0]) && !$past(pos_s[0])))
    else $error("rails not sampled on the same edge");
  a_pos_pulse: assert property (s_dual_on ##0 pos_s[0] |=> line_out_tip[0] && !line_out_ring[0])
    else $error("positive rail high without positive pulse");
  a_no_pos_pulse: assert property (s_dual_on ##0 !pos_s[0] |=> !line_out_tip[0])
    else $error("positive pulse with positive rail low");
  a_viol_polarity: assert property (s_v_slot |=> line_out_tip[0] == $past(last_p[0])
    && line_out_ring[0] == !$past(last_p[0]))
    else $error("violation pulse polarity wrong");
  a_host_ignores: assert property (samp[0] && hostm && single && ctrl[`CTRL_HDB3_BIT]
    && dly[0][2:0] == 3'h0 && !pos_s[0] && sub[0][2:0] == '0 |=> sub[0][0] == SUB_V)
    else $error("host single rail zero run not substituted");
  a_code_select: assert property (samp[0] && !hostm && single && neg_s[0] |=> sub[0][0] == SUB_NONE)
    else $error("coding active while line code select off");
  a_lost_wins: assert property (lost_set[0] |=> lost)
    else $error("overwritten sample not flagged");
endmodule

// ===== logic/lineif_consts.svh
// Purpose: Shared offsets, field positions and sizes of the transmit input stage.
// Assumes: Included by its bare name from every design file except the package.
// Notes:   Definitions only.
`ifndef LINEIF_CONSTS_SVH
`define LINEIF_CONSTS_SVH

`define N_CH           4
`define FIFO_DEPTH     8
`define FIFO_WIDTH     4
`define DLY_LEN        8

// Register byte offsets (low address byte)
`define ADDR_CTRL      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_DATA      8'h08

// Control fields, used only in host mode (except the code select bit)
`define CTRL_EDGE_BIT  0
`define CTRL_SINGLE_BIT 1
`define CTRL_HDB3_BIT  2
`define CTRL_ON_LSB    4
`define CTRL_MASK      32'h0000_00F7
`define CTRL_RESET     32'h0000_0000

// Status fields
`define ST_HOST_BIT    8
`define ST_LOST_BIT    9
`define ST_AVAIL_BIT   10
`define DATA_VALID_BIT 4

`endif

// ===== logic/lineif_pkg.sv
// Purpose: Types of the transmit input stage.
// Assumes: Nothing beyond the constants header.
// Notes:   Substitution codes ride beside each delayed data bit.
package lineif_pkg;

  typedef logic [1:0] code_t;

  // Per-bit substitution marks
  typedef enum logic [1:0] {
    SUB_NONE = 2'h0,
    SUB_V    = 2'h1,
    SUB_B    = 2'h3,
    SUB_H    = 2'h2
  } sub_e;

endpackage

// ===== logic/sym_fifo_if.sv
// Purpose: Carrier between the sampling logic and the symbol FIFO.
// Assumes: One filler, one drainer.
// Notes:   Valid/ready on both sides.
`timescale 1ns/1ns
`include "lineif_consts.svh"
interface sym_fifo_if;
  logic                   in_valid;
  logic                   in_ready;
  logic [`FIFO_WIDTH-1:0] in_data;
  logic                   out_valid;
  logic                   out_ready;
  logic [`FIFO_WIDTH-1:0] out_data;

  modport fill  (output in_valid, in_data, input in_ready);
  modport drain (input out_valid, out_data, output out_ready);
  modport fifo  (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// ===== logic/sym_fifo.sv
// Purpose: Small FIFO with registered head word.
// Assumes: DEPTH is a power of two.
// Notes:   out_valid drops for one cycle after each pop, so a pop can never repeat.
`timescale 1ns/1ns
`include "lineif_consts.svh"
module sym_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  sym_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Honest full: refuse only when every slot holds a word
  assign f.in_ready = (count != (AW+1)'(DEPTH));
  assign push       = f.in_valid && f.in_ready;
  assign pop        = f.out_valid && f.out_ready;

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= f.in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head register; lags storage by one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      f.out_valid <= 1'b0;
      f.out_data  <= '0;
    end else begin
      f.out_valid <= (count != '0) && !pop;
      f.out_data  <= mem[rptr];
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_b)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_pop_gap: assert property (@(posedge clk) disable iff (!rst_b)
    pop |=> !f.out_valid)
    else $error("fifo head valid right after pop");
endmodule

// ===== bench/framer_model.sv
// Purpose: Framer model driving link clocks and rails of four channels.
// Assumes: Rails fall to the pulled-down level when no frame runs.
// Notes:   Unclocked channels still see rail data, to expose crosstalk.
`timescale 1ns/1ns
module framer_model (
  input  wire logic [3:0] run,
  input  wire logic       rise_sel,
  input  wire logic [3:0] pos_bit,
  input  wire logic [3:0] neg_bit,
  output logic      [3:0] tclk,
  output logic      [3:0] pos,
  output logic      [3:0] neg
);
  logic base;

  ////////////////////////////////////////
  // Link clock of 320 ns, parked low between frames
  initial begin
    base = 1'b0;
    pos = 4'h0;
    neg = 4'h0;
    #7;
    forever begin
      #160;
      base = (run != 4'h0) ? ~base : 1'b0;
    end
  end
  assign tclk = {4{base}} & run;

  ////////////////////////////////////////
  // Launch a quarter period late, so the wrong edge shows up in timing
  always @(base) begin
    if (base == rise_sel) begin
      #80;
      pos = (run != 4'h0) ? pos_bit : 4'h0;
      neg = (run != 4'h0) ? neg_bit : 4'h0;
    end
  end

  // Rails drop to the pulled-down level as soon as the frame stops
  always @(run) begin
    if (run == 4'h0) begin
      pos = 4'h0;
      neg = 4'h0;
    end
  end
endmodule

// ===== bench/tb_lineif_tx_data_input.sv
// Purpose: Self-checking bench of the transmit input stage.
// Assumes: Zero-wait register bus; framer model makes the link clocks.
// Notes:   Single rail polarity is judged relative to the first mark.
`timescale 1ns/1ns
`include "lineif_consts.svh"
module tb_lineif_tx_data_input;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic        host_mode = 1'b0;
  logic        rail_single = 1'b0;
  logic        tx_clock_edge_select = 1'b1;
  logic        sel_rise = 1'b1;
  logic [3:0]  tx_output_on = 4'hF;
  logic [3:0]  tx_channel_clock, tx_positive_rail, tx_negative_rail;
  logic [3:0]  line_out_tip, line_out_tip_oe, line_out_ring, line_out_ring_oe;
  logic [3:0]  run = 4'h0, pos_bit = 4'h0, neg_bit = 4'h0, early_tip;
  logic [3:0]  p_tab [5] = '{4'h5, 4'h2, 4'h1, 4'h7, 4'h7};
  logic [3:0]  n_tab [5] = '{4'h2, 4'h5, 4'h1, 4'h0, 4'h0};
  int          b8zs_tab [11] = '{1, -1, 0, 0, 0, -1, 1, 0, 1, -1, 1};
  int          ami_tab [11] = '{1, -1, 0, 0, 0, 0, 0, 0, 0, 0, 1};
  int          hdb3_tab [11] = '{1, -1, 1, 0, 0, 1, -1, 0, 0, -1, 1};
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cnt;

  ////////////////////////////////////////
  // Clock and the two parties
  always #20 clk = ~clk;

  lineif_tx_data_input dut_u (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .host_mode(host_mode), .rail_single(rail_single),
    .tx_clock_edge_select(tx_clock_edge_select), .tx_output_on(tx_output_on),
    .tx_channel_clock(tx_channel_clock), .tx_positive_rail(tx_positive_rail),
    .tx_negative_rail(tx_negative_rail), .line_out_tip(line_out_tip),
    .line_out_tip_oe(line_out_tip_oe), .line_out_ring(line_out_ring),
    .line_out_ring_oe(line_out_ring_oe)
  );

  framer_model framer_u (
    .run(run), .rise_sel(sel_rise), .pos_bit(pos_bit), .neg_bit(neg_bit),
    .tclk(tx_channel_clock), .pos(tx_positive_rail), .neg(tx_negative_rail)
  );

  ////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One single transfer; waits on ready without assuming a latency
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    n = 0;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    if (n >= 50) n_mismatch++;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    if (n >= 50) n_mismatch++;
    r = hrdata;
    check(hresp, 1'b0);
  endtask

  // Waits for a sampling edge, notes the output just after it, offers new bits
  task automatic tick(input logic [3:0] p, input logic [3:0] n);
    if (sel_rise)
      @(posedge tx_channel_clock[0]);
    else
      @(negedge tx_channel_clock[0]);
    #40;
    early_tip = line_out_tip;
    pos_bit = p;
    neg_bit = n;
    #160;
  endtask

  // Dual rail stream on channels 0..2; channel 3 sees data but no clock
  task automatic dual(input logic [3:0] on);
    logic [3:0] et, pt;
    for (int k = 0; k < 5; k++) begin
      tick(p_tab[k], n_tab[k]);
      if (k > 1) check(early_tip, pt);
      if (k > 0) begin
        et = p_tab[k - 1] & 4'h7 & on;
        check(line_out_tip, et);
        check(line_out_ring, n_tab[k - 1] & ~p_tab[k - 1] & 4'h7 & on);
        check({line_out_tip_oe, line_out_ring_oe}, {on, on});
        pt = et;
      end
    end
  endtask

  // Single rail: marks 1,1, eight zeros, 1; output lags eight line bits
  task automatic single_run(input int tab [11], input logic toggle);
    logic pol;
    int   e;
    for (int j = 0; j < 20; j++) begin
      tick({3'h0, (j < 2 || j == 10)}, toggle ? {4{j[0]}} : 4'h1);
      if (j == 9) pol = line_out_tip[0];
      if (j > 8) begin
        e = tab[j - 9];
        check({line_out_tip[0], line_out_ring[0]},
              e == 0 ? 2'b00 : (((e > 0) ^ !pol) ? 2'b10 : 2'b01));
      end
    end
  endtask

  ////////////////////////////////////////
  // Watchdog, far beyond the expected 30 us run
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    check({hreadyout, line_out_tip_oe, line_out_ring_oe}, 9'h100);
    rst_b <= 1'b1;
    ahb(1'b0, `ADDR_CTRL, 32'h0000_0000, rd);
    check(rd, `CTRL_RESET);
    ahb(1'b1, `ADDR_CTRL, 32'hFFFF_FFFF, rd);
    ahb(1'b0, `ADDR_CTRL, 32'h0000_0000, rd);
    check(rd, `CTRL_MASK);
    ahb(1'b0, 8'h0C, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    ahb(1'b1, `ADDR_CTRL, 32'h0000_0000, rd);
    // Hardware mode, dual rail, both edges
    run = 4'h7;
    dual(4'hF);
    @(posedge clk);
    tx_clock_edge_select <= 1'b0;
    sel_rise = 1'b0;
    dual(4'hF);
    // Output-on low must release both lines while data flows
    @(posedge clk);
    tx_output_on <= 4'h0;
    repeat (6) @(posedge clk);
    #1 check({line_out_tip, line_out_ring, line_out_tip_oe, line_out_ring_oe}, 16'h0000);
    // Host mode: edge and output-on from the register, select pin grounded
    @(posedge clk);
    tx_output_on <= 4'hF;
    host_mode <= 1'b1;
    tx_clock_edge_select <= 1'b0;
    sel_rise = 1'b1;
    ahb(1'b1, `ADDR_CTRL, 32'h0000_0031, rd);
    dual(4'h3);
    // Log buffer: full plus one pending sample per clocked channel
    run = 4'h0;
    repeat (20) @(posedge clk);
    ahb(1'b0, `ADDR_STATUS, 32'h0000_0000, rd);
    check(rd & 32'h0000_07FF, {21'h00_0000, 3'h7, n_tab[3] & 4'h7, p_tab[3] & 4'h7});
    ahb(1'b1, `ADDR_STATUS, 32'h0000_0200, rd);
    ahb(1'b0, `ADDR_STATUS, 32'h0000_0000, rd);
    check(rd[9], 1'b0);
    cnt = 0;
    repeat (16) begin
      ahb(1'b0, `ADDR_DATA, 32'h0000_0000, rd);
      cnt = cnt + int'(rd[4] === 1'b1);
    end
    check(cnt, `FIFO_DEPTH + 3);
    check(rd[4], 1'b0);
    // Host single rail with zero substitution; negative rail toggles
    run = 4'h1;
    ahb(1'b1, `ADDR_CTRL, 32'h0000_0013, rd);
    single_run(b8zs_tab, 1'b1);
    // Hardware single rail, negative rail high turns the encoder off
    @(posedge clk);
    host_mode <= 1'b0;
    rail_single <= 1'b1;
    tx_clock_edge_select <= 1'b1;
    tx_output_on <= 4'h1;
    single_run(ami_tab, 1'b0);
    // Host single rail, four-zero code; select pin grounded again
    ahb(1'b1, `ADDR_CTRL, 32'h0000_0017, rd);
    @(posedge clk);
    host_mode <= 1'b1;
    tx_clock_edge_select <= 1'b0;
    single_run(hdb3_tab, 1'b1);
    give_verdict();
  end
endmodule
